// ==== testbench/data_file_model.sv ====
// Data memory file model beside the move unit.
// Takes writes at the clock edge; reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module data_file_model
  import move_exec_pkg::*;
(
  input  wire logic        clk,
  input  wire mem_wr_t     wr,
  input  wire logic [15:0] raddr,
  output logic [7:0]       rdata
);
  logic [7:0] mem [65536];
  // Writes land at the address that the unit resolved.
  always_ff @(posedge clk)
  begin
    if (wr.wr)
      mem[wr.addr] <= wr.data;
  end
  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// ==== testbench/literal_and_indirect_move_exec_tb_top.sv ====
// Self-checking bench for the move execution unit.
// Drives decoded instructions 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin comparisons++; if ((a)!==(b)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module literal_and_indirect_move_exec_tb_top import move_exec_pkg::*;;
  typedef struct packed {op_t op; logic [7:0] l; logic [1:0] m; logic [5:0] f;
    logic [1:0] w; logic [15:0] ad; logic [15:0] p;} row_t;
  logic clk = 0, nrst = 0, pc_advance, flags_write;
  instr_t instr = '0;
  logic [7:0] accumulator, option_config, rd;
  logic [6:0] program_counter_high_latch;
  logic [15:0] indirect_pointer0, indirect_pointer1;
  mem_wr_t mem_wr;
  int failures = 0, comparisons = 0, cyc = 0;
  row_t rows [9] = '{'{OP_LIT_TO_ACC, 8'h5A, 2'h0, 6'h00, 2'h0, 16'h0000, 16'h0000},
    '{OP_ACC_IND, 8'h00, 2'h1, 6'h00, 2'h3, 16'hFFFF, 16'hFFFF},
    '{OP_ACC_IND, 8'h00, 2'h0, 6'h00, 2'h3, 16'h0000, 16'h0000},
    '{OP_ACC_IND, 8'h00, 2'h3, 6'h00, 2'h3, 16'h0000, 16'hFFFF},
    '{OP_ACC_IND, 8'h00, 2'h2, 6'h00, 2'h3, 16'hFFFF, 16'h0000},
    '{OP_ACC_IND_REL, 8'h00, 2'h0, 6'h20, 2'h3, 16'hFFE0, 16'h0000},
    '{OP_ACC_IND_REL, 8'h00, 2'h0, 6'h1F, 2'h3, 16'h001F, 16'h0000},
    '{OP_ACC_TO_FILE, 8'h7F, 2'h0, 6'h00, 2'h2, 16'h007F, 16'h0000},
    '{OP_IDLE, 8'h00, 2'h0, 6'h00, 2'h0, 16'h0000, 16'h0000}};
  always #2.5 clk = ~clk;
  literal_and_indirect_move_exec u_dut (.*);
  data_file_model u_mem (.clk, .wr(mem_wr), .raddr(indirect_pointer1), .rdata(rd));
  function automatic instr_t mk(op_t o, logic [7:0] l, logic s, logic [1:0] m, logic [5:0] f);
    return '{1'b1, o, l, l[6:0], s, m, f};
  endfunction
  // Presents one instruction and waits until its results have landed.
  task automatic step(instr_t i);
    instr <= i;
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk)
  begin
    if (++cyc > 200)
    begin
      failures++;
      tally_and_finish;
    end
  end
  // Reset, the table of back-to-back cases, then the awkward ones.
  initial
  begin
    repeat (12) @(posedge clk);
    #1 nrst = 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({accumulator, option_config, program_counter_high_latch}, 23'h007F80)
    foreach (rows[k])
    begin
      step(mk(rows[k].op, rows[k].l, 1'b0, rows[k].m, rows[k].f));
      `CHK(mem_wr.wr, rows[k].w[1])
      if (rows[k].w[1]) `CHK({mem_wr.indirect, mem_wr.addr}, {rows[k].w[0], rows[k].ad})
      `CHK({indirect_pointer0, accumulator}, {rows[k].p, 8'h5A})
      `CHK({pc_advance, flags_write}, 2'h2)
      $display("row %0d done", k);
    end
    step(mk(OP_PAGE_LATCH, 8'hFF, 1'b0, 2'h0, 6'h00));
    `CHK(program_counter_high_latch, 7'h7F)
    step(mk(OP_ACC_TO_OPT, 8'h00, 1'b0, 2'h0, 6'h00));
    `CHK(option_config, 8'h5A)
    step(mk(OP_ACC_IND, 8'h00, 1'b1, MODE_PRE_INC, 6'h00));
    step(mk(OP_IDLE, 8'h00, 1'b0, 2'h0, 6'h00));
    `CHK({indirect_pointer1, rd, indirect_pointer0}, 40'h00015A0000)
    $display("hand tests done");
    tally_and_finish;
  end
endmodule
bind literal_and_indirect_move_exec move_exec_assertions u_chk (.*);
`default_nettype wire

// ==== testbench/move_exec_assertions.sv ====
// Checker for the move execution unit.
// Bound to the unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module move_exec_assertions
  import move_exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire instr_t      instr,
  input wire logic        pc_advance,
  input wire logic [7:0]  accumulator,
  input wire logic [6:0]  program_counter_high_latch,
  input wire logic [7:0]  option_config,
  input wire logic [15:0] indirect_pointer0,
  input wire logic [15:0] indirect_pointer1,
  input wire mem_wr_t     mem_wr,
  input wire logic        flags_write
);
  // Every check samples on the rising edge and rests during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic v = instr.valid;
  wire op_t o = instr.op;
  wire logic i0 = v && o == OP_ACC_IND && !instr.ptr_sel;
  wire logic [1:0] md = instr.pointer_update_mode;
  AST_PAGE: assert property (v && o == OP_PAGE_LATCH |=>
    program_counter_high_latch == $past(instr.literal[6:0])) else $error("page latch");
  AST_ACC: assert property (v && o == OP_LIT_TO_ACC |=>
    accumulator == $past(instr.literal)) else $error("literal load");
  AST_FILE: assert property (v && o == OP_ACC_TO_FILE |=> mem_wr.wr &&
    mem_wr.addr[6:0] == $past(instr.file_addr) && mem_wr.data == $past(accumulator))
    else $error("file store");
  AST_PRE: assert property (i0 && md == MODE_PRE_INC |=>
    mem_wr.addr == $past(indirect_pointer0) + 16'h1) else $error("pre inc");
  AST_PDEC: assert property (i0 && md == MODE_POST_DEC |=> mem_wr.addr ==
    $past(indirect_pointer0) && indirect_pointer0 == $past(indirect_pointer0) - 16'h1)
    else $error("post dec");
  AST_REL: assert property (v && o == OP_ACC_IND_REL |-> ##1 mem_wr.indirect &&
    $stable(indirect_pointer0) && $stable(indirect_pointer1)) else $error("relative");
  AST_OPT: assert property (v && o == OP_ACC_TO_OPT |=>
    option_config == $past(accumulator)) else $error("option load");
  AST_FLAG: assert property (!flags_write) else $error("flag write");
  AST_IDLE: assert property (v && o == OP_IDLE |=>
    pc_advance && !mem_wr.wr && $stable(accumulator)) else $error("idle");
  cover property (i0 && md == MODE_PRE_DEC);
  cover property (v && o == OP_ACC_IND_REL);
  cover property (v && o == OP_PAGE_LATCH);
endmodule
`default_nettype wire

// ==== verilog/literal_and_indirect_move_exec.sv ====
// Execution unit for the literal, store and indirect move instructions.
// Assumes the decode stage holds the instruction for one cycle and memory takes writes at once.
// Summary of operation
// - Page-latch load copies the 7-bit literal into the page latch; flags untouched.
// - Literal load places the 8-bit literal into the accumulator in one cycle.
// - File store writes the accumulator to the 7-bit file address in one cycle.
// - Indirect ports hold nothing; accesses go to the address in the selected pointer.
// - Indirect store decodes modes 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Address is pointer+1, pointer-1, pointer+offset(-32..31), or pointer for post modes.
// - Pointer afterwards is +1 for increments, -1 for decrements, unchanged if relative.
// - Pointers are 16 bits and wrap modulo 65536 without fault.
// - Pointer updates and indirect stores alter no status flags.
// - Option load copies the accumulator into the option register.
`timescale 1ns/1ps
`default_nettype none

// Execution model in brief.
// Every valid instruction is taken at a rising edge and its effect is visible one cycle
// later. There is no stall and no multi-cycle instruction, so a new instruction may be
// presented on every cycle, back to back.
// Stores always use the accumulator value from before the edge at which they are taken,
// so a literal load followed at once by a store writes the new literal one cycle on.
// The write toward the data file is a one-cycle pulse; the data file must take it at once.
// Indirect stores carry a flag so that the data file can tell them from direct stores.
// Unknown operation codes and cycles without a valid instruction change nothing.
// No status flag is ever written by this unit, so its flag write strobe stays low.
// The widths are parameters for clarity only; the package carriers fix them, and the
// elaboration check below refuses any other value.

module literal_and_indirect_move_exec
  import move_exec_pkg::*;
#(
  parameter int ACC_WIDTH    = 8,
  parameter int PAGE_WIDTH   = 7,
  parameter int PTR_WIDTH    = 16,
  parameter int OFFSET_WIDTH = 6
)
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire instr_t                instr,
  output logic                       pc_advance,
  output logic [ACC_WIDTH-1:0]       accumulator,
  output logic [PAGE_WIDTH-1:0]      program_counter_high_latch,
  output logic [ACC_WIDTH-1:0]       option_config,
  output logic [PTR_WIDTH-1:0]       indirect_pointer0,
  output logic [PTR_WIDTH-1:0]       indirect_pointer1,
  output mem_wr_t                    mem_wr,
  output logic                       flags_write
);

  // Refuses widths that the package carriers cannot serve and a reset chain of fewer than two stages.
  if (ACC_WIDTH != 8 || PAGE_WIDTH != 7 || PTR_WIDTH != 16 || OFFSET_WIDTH != 6)
  begin : g_bad_width
    $error("Unsupported width parameter for the move execution unit.");
  end
  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("The reset release chain needs at least two stages.");
  end

  // State of the unit apart from the reset chain; every output is one field of it.
  typedef struct packed {
    logic                    pc_advance;
    logic                    flags_wr;
    logic [ACC_WIDTH-1:0]    acc;
    logic [PAGE_WIDTH-1:0]   page;
    logic [ACC_WIDTH-1:0]    option;
    logic [PTR_WIDTH-1:0]    ptr0;
    logic [PTR_WIDTH-1:0]    ptr1;
    mem_wr_t                 wr;
  } state_t;

  // Value of the whole state while reset is asserted.
  localparam state_t STATE_RESET = '{
    pc_advance: 1'h0,
    flags_wr:   1'h0,
    acc:        ACC_RESET,
    page:       PAGE_RESET,
    option:     OPTION_RESET,
    ptr0:       POINTER_RESET,
    ptr1:       POINTER_RESET,
    wr:         '0
  };

  // Offset that steps a pointer up by one; all ones steps it down by one.
  localparam logic [OFFSET_WIDTH-1:0] STEP_UP   = {{(OFFSET_WIDTH-1){1'h0}}, 1'h1};
  localparam logic [OFFSET_WIDTH-1:0] STEP_DOWN = '1;

  state_t                 state;
  state_t                 next_state;
  logic [SYNC_STAGES-1:0] rst_sync;
  logic                   rst_n;

  // Sign-extends an offset and adds it to a pointer; the sum wraps at the pointer width.
  function automatic logic [PTR_WIDTH-1:0] ptr_add
  (
    input logic [PTR_WIDTH-1:0]    p,
    input logic [OFFSET_WIDTH-1:0] k
  );
    ptr_add = p + {{(PTR_WIDTH-OFFSET_WIDTH){k[OFFSET_WIDTH-1]}}, k};
  endfunction

  // Steps a pointer by one, down when the mode's low bit is set.
  function automatic logic [PTR_WIDTH-1:0] ptr_step
  (
    input logic [PTR_WIDTH-1:0] p,
    input logic                 down
  );
    ptr_step = down ? ptr_add(p, STEP_DOWN) : ptr_add(p, STEP_UP);
  endfunction

  // Resolves the write address of a moded store: pre modes use the stepped pointer.
  function automatic logic [PTR_WIDTH-1:0] moded_address
  (
    input logic [PTR_WIDTH-1:0] p,
    input logic [1:0]           mode
  );
    case (mode)
      MODE_PRE_INC:  moded_address = ptr_step(p, 1'h0);
      MODE_PRE_DEC:  moded_address = ptr_step(p, 1'h1);
      MODE_POST_INC: moded_address = p;
      MODE_POST_DEC: moded_address = p;
      default:       moded_address = p;
    endcase
  endfunction

  // Reset release passes through two flip-flops; assertion is immediate.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= '0;
    else
      rst_sync <= {rst_sync[SYNC_STAGES-2:0], 1'h1};
  end

  // Only the last stage of the chain resets the rest of the unit.
  assign rst_n = rst_sync[SYNC_STAGES-1];

  // Executes the presented instruction and forms the next state.
  always_comb
  begin
    logic [PTR_WIDTH-1:0] ptr;
    logic [PTR_WIDTH-1:0] ptr_after;
    ptr                   = instr.ptr_sel ? state.ptr1 : state.ptr0;
    ptr_after             = ptr_step(ptr, instr.pointer_update_mode[0]);
    next_state            = state;
    next_state.wr         = '0;
    next_state.flags_wr   = 1'h0;
    next_state.pc_advance = instr.valid;
    if (instr.valid)
    begin
      case (instr.op)
        OP_PAGE_LATCH:
        begin
          // Only the page latch changes; no flag is touched.
          next_state.page = instr.literal[PAGE_WIDTH-1:0];
        end
        OP_LIT_TO_ACC:
        begin
          // The whole literal lands in the accumulator in one cycle.
          next_state.acc = instr.literal;
        end
        OP_ACC_TO_FILE:
        begin
          // Direct store: the file address is zero-extended onto the memory address.
          next_state.wr.wr   = 1'h1;
          next_state.wr.addr = {{(PTR_WIDTH-7){1'h0}}, instr.file_addr};
          next_state.wr.data = state.acc;
        end
        OP_ACC_TO_OPT:
        begin
          // The option register takes the accumulator as it stood before this edge.
          next_state.option = state.acc;
        end
        OP_ACC_IND, OP_ACC_IND_REL:
        begin
          // The indirect port is never stored; the write goes to the pointer's target.
          next_state.wr.wr       = 1'h1;
          next_state.wr.indirect = 1'h1;
          next_state.wr.data     = state.acc;
          if (instr.op == OP_ACC_IND_REL)
          begin
            // Relative form leaves both pointers as they are.
            next_state.wr.addr = ptr_add(ptr, instr.offset);
          end
          else
          begin
            next_state.wr.addr = moded_address(ptr, instr.pointer_update_mode);
            // Both increment modes step up, both decrement modes step down.
            if (instr.ptr_sel)
              next_state.ptr1 = ptr_after;
            else
              next_state.ptr0 = ptr_after;
          end
        end
        default:
        begin
          // The idle instruction and unknown codes leave every register alone.
          next_state.wr = '0;
        end
      endcase
    end
  end

  // Registers the whole state on every edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= STATE_RESET;
    else
      state <= next_state;
  end

  // Outputs come straight from the state flip-flops.
  assign pc_advance                 = state.pc_advance;
  assign accumulator                = state.acc;
  assign program_counter_high_latch = state.page;
  assign option_config              = state.option;
  assign indirect_pointer0          = state.ptr0;
  assign indirect_pointer1          = state.ptr1;
  assign mem_wr                     = state.wr;
  assign flags_write                = state.flags_wr;

endmodule

`default_nettype wire

// ==== verilog/move_exec_pkg.sv ====
// Package for the literal and indirect move execution unit.
// Assumes a decode stage that presents one decoded instruction per cycle.
package move_exec_pkg;

  // Operation codes presented by the decode stage.
  typedef enum logic [2:0] {
    OP_IDLE        = 3'h0,
    OP_PAGE_LATCH  = 3'h1,
    OP_LIT_TO_ACC  = 3'h2,
    OP_ACC_TO_FILE = 3'h3,
    OP_ACC_TO_OPT  = 3'h4,
    OP_ACC_IND     = 3'h5,
    OP_ACC_IND_REL = 3'h6
  } op_t;

  // Pointer update modes of the indirect store.
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // Reset values.
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [6:0]  PAGE_RESET    = 7'h00;
  localparam logic [7:0]  OPTION_RESET  = 8'hFF;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam int          SYNC_STAGES   = 2;

  // Decoded instruction from the decode stage.
  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [7:0]  literal;
    logic [6:0]  file_addr;
    logic        ptr_sel;
    logic [1:0]  pointer_update_mode;
    logic [5:0]  offset;
  } instr_t;

  // Write request toward the data memory file.
  typedef struct packed {
    logic        wr;
    logic        indirect;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_t;

endpackage
